/* common/sas_pkg.sv */
// Constants, register map and types for the SAR converter auto sequencer.
// What this block does
// - Converter leaves reset powered down; software clears power-down before converting.
// - Converter clock is the 24 MHz clock divided by divider field plus one, or by two when the field is zero.
// - Sequencer samples only while the channel enable bit is one.
// - Set phase lasts the four-bit set-length field in 24 MHz cycles.
// - During Set, the converter control inputs follow the programmed settings.
// - Positive input select is bits 7:4, negative input select bits 3:0.
// - Two-bit reference select drives the converter; value 2 picks 1.2 V.
// - Two-bit input scaling select chooses unity or one-eighth scaling.
// - Two-bit resolution select covers 8, 10, 12 or 14 bits; 3 is 14.
// - Result is always 16 bits, sign extended above the valid bits.
// - Four-bit sampling time field sets settle cycles; value 3 gives 12.
// - Capture start pulses run; capture end latches the converter output.
// - Capture lasts a ten-bit count: two upper bits and eight lower bits.
// - Valid flag sets at capture end and clears automatically.
// - Result updates at capture only while the hold bit is zero.
// - Sample period equals Set length plus Capture length.
package sas_pkg;
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_CLKDIV = 12'h004;
	localparam logic [11:0] OFF_SEQ = 12'h008;
	localparam logic [11:0] OFF_SETLEN = 12'h00c;
	localparam logic [11:0] OFF_CAPLO = 12'h010;
	localparam logic [11:0] OFF_ANALOG = 12'h014;
	localparam logic [11:0] OFF_INSEL = 12'h018;
	localparam logic [11:0] OFF_RESULT = 12'h01c;
	localparam logic [11:0] OFF_STATUS = 12'h020;
	localparam logic [11:0] OFF_IRQ = 12'h024;
	localparam logic [11:0] OFF_MASK = 12'h028;
	// CTRL: bit0 power down, bit1 hold.
	localparam int CTRL_PD_BIT = 0;
	localparam int CTRL_HOLD_BIT = 1;
	localparam logic CTRL_PD_RST = 1'b1;
	localparam logic CTRL_HOLD_RST = 1'b0;
	localparam logic [2:0] CLKDIV_RST = 3'h3;
	// SEQ: bit2 channel enable, bits 5:4 max state index.
	localparam int SEQ_EN_BIT = 2;
	localparam int SEQ_MAX_LSB = 4;
	localparam logic [1:0] SEQ_MAX_RST = 2'h0;
	localparam logic [1:0] SEQ_MAX_RUN = 2'h2;
	// SETLEN: bits 3:0 set length, bits 7:6 capture length upper bits.
	localparam int SETLEN_CAPHI_LSB = 6;
	// ANALOG: 1:0 vref, 3:2 resolution, 4 diff, 7:6 scale, 11:8 tsamp.
	localparam int AN_VREF_LSB = 0;
	localparam int AN_RES_LSB = 2;
	localparam int AN_DIFF_BIT = 4;
	localparam int AN_SCALE_LSB = 6;
	localparam int AN_TSAMP_LSB = 8;
	localparam logic [1:0] VREF_RST = 2'h0;
	localparam logic [1:0] RES_RST = 2'h3;
	localparam logic [1:0] RES_8 = 2'h0;
	localparam logic [1:0] RES_10 = 2'h1;
	localparam logic [1:0] RES_12 = 2'h2;
	localparam logic [1:0] SCALE_RST = 2'h0;
	localparam logic [3:0] TSAMP_RST = 4'h0;
	localparam logic [3:0] TSAMP_MULT = 4'h3;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_OVR_BIT = 1;
	localparam int RESULT_W = 16;
	typedef enum logic [1:0] {
		SAS_IDLE = 2'b00,
		SAS_SET = 2'b01,
		SAS_CAPTURE = 2'b10
	} sas_state_t;
endpackage

/* design/sas_clkdiv.sv */
// Converter clock divider: divides the system clock by div plus one, or by two when div is zero.
`timescale 1ns/100ps
module sas_clkdiv #(
	parameter int DIV_W = 3
) (
	// System.
	input wire logic clock,
	input wire logic reset,
	// Control.
	input wire logic enable,
	input wire logic [DIV_W-1:0] div,
	// Divided clock as a register and a tick in the last system cycle of each count of div plus one.
	output logic conv_clk,
	output logic tick
);
	logic [DIV_W-1:0] cnt_ff;
	logic [DIV_W-1:0] nxt_cnt;
	logic clk_ff;
	logic nxt_clk;
	wire wrap = (cnt_ff >= div);
	wire [DIV_W:0] half = ({1'b0, div} + {{DIV_W{1'b0}}, 1'b1}) >> 1;
	assign nxt_cnt = (!enable || wrap) ? '0 : cnt_ff + 1'b1;
	// The output is high for the first half of every period; a zero divider toggles it every cycle, dividing by two.
	assign nxt_clk = enable && ({1'b0, nxt_cnt} < half || div == '0) && !(div == '0 && clk_ff);
	always_ff @(posedge clock) begin
		if (reset) begin
			cnt_ff <= '0;
			clk_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			clk_ff <= nxt_clk;
		end
	end
	assign conv_clk = clk_ff;
	assign tick = enable && wrap;
endmodule

/* design/sas_top.sv */
// Auto sequencer for the SAR converter with APB registers and interrupt.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module sas_top #(
	parameter int DIV_W = 3,
	parameter int SET_W = 4,
	parameter int CAP_W = 10
) (
	// System.
	input wire logic clock,
	input wire logic reset,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt.
	output logic irq,
	// Converter core controls.
	output logic conv_power_down,
	output logic conv_clk,
	output logic conv_run,
	output logic conv_diff_mode,
	output logic [3:0] conv_ain_pos,
	output logic [3:0] conv_ain_neg,
	output logic [1:0] conv_vref_sel,
	output logic [1:0] input_scale_select,
	output logic [1:0] conv_res_sel,
	output logic [5:0] conv_settle_cycles,
	// Converter core data, from another clock domain.
	input wire logic [15:0] conv_data,
	// Sequencer status.
	output logic result_valid_flag,
	output logic [15:0] result
);
	logic pd_ff;
	logic hold_ff;
	logic [DIV_W-1:0] div_ff;
	logic en_ff;
	logic [1:0] maxst_ff;
	logic [SET_W-1:0] setlen_ff;
	logic [1:0] caphi_ff;
	logic [7:0] caplo_ff;
	logic [11:0] analog_ff;
	logic [7:0] insel_ff;
	logic [1:0] stat_ff;
	logic [1:0] mask_ff;
	sas_pkg::sas_state_t st_ff;
	sas_pkg::sas_state_t nxt_st;
	logic [CAP_W-1:0] cnt_ff;
	logic [CAP_W-1:0] nxt_cnt;
	logic [15:0] data_s1_ff;
	logic [15:0] data_s2_ff;
	logic [15:0] result_ff;
	logic valid_ff;
	logic run_ff;
	logic [5:0] settle_ff;
	logic [1:0] vref_ff;
	logic [1:0] scale_ff;
	logic [1:0] res_ff;
	logic diff_ff;
	logic [7:0] ain_ff;

	// Bus decode.
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire rd = acc && !pwrite;
	wire hit_ctrl = paddr == sas_pkg::OFF_CTRL;
	wire hit_div = paddr == sas_pkg::OFF_CLKDIV;
	wire hit_seq = paddr == sas_pkg::OFF_SEQ;
	wire hit_setlen = paddr == sas_pkg::OFF_SETLEN;
	wire hit_caplo = paddr == sas_pkg::OFF_CAPLO;
	wire hit_analog = paddr == sas_pkg::OFF_ANALOG;
	wire hit_insel = paddr == sas_pkg::OFF_INSEL;
	wire hit_result = paddr == sas_pkg::OFF_RESULT;
	wire hit_status = paddr == sas_pkg::OFF_STATUS;
	wire hit_irq = paddr == sas_pkg::OFF_IRQ;
	wire hit_mask = paddr == sas_pkg::OFF_MASK;
	wire mapped = hit_ctrl | hit_div | hit_seq | hit_setlen | hit_caplo | hit_analog
		| hit_insel | hit_result | hit_status | hit_irq | hit_mask;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;

	// Sequencer.
	// Running needs power up, enable and the two-state index; other indexes park the sequencer.
	wire run_ok = !pd_ff && en_ff && maxst_ff == sas_pkg::SEQ_MAX_RUN;
	wire [CAP_W-1:0] cap_len = {caphi_ff, caplo_ff};
	wire [CAP_W-1:0] set_len = {{(CAP_W-SET_W){1'b0}}, setlen_ff};
	wire set_done = st_ff == sas_pkg::SAS_SET && cnt_ff + 1'b1 >= set_len;
	wire cap_done = st_ff == sas_pkg::SAS_CAPTURE && cnt_ff + 1'b1 >= cap_len;
	wire enter_cap = set_done && run_ok;
	// The divider tick stays open: the core counts its own settle cycles on the divided clock.

	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff + 1'b1;
		if (!run_ok) begin
			nxt_st = sas_pkg::SAS_IDLE;
			nxt_cnt = '0;
		end else begin
			unique case (st_ff)
				sas_pkg::SAS_IDLE: begin
					nxt_st = sas_pkg::SAS_SET;
					nxt_cnt = '0;
				end
				sas_pkg::SAS_SET: begin
					if (set_done) begin
						nxt_st = sas_pkg::SAS_CAPTURE;
						nxt_cnt = '0;
					end
				end
				sas_pkg::SAS_CAPTURE: begin
					if (cap_done) begin
						nxt_st = sas_pkg::SAS_SET;
						nxt_cnt = '0;
					end
				end
				default: begin
					nxt_st = sas_pkg::SAS_IDLE;
					nxt_cnt = '0;
				end
			endcase
		end
	end

	// Sign extension above the selected resolution.
	wire [15:0] raw = data_s2_ff;
	wire [15:0] ext8 = {{8{raw[7]}}, raw[7:0]};
	wire [15:0] ext10 = {{6{raw[9]}}, raw[9:0]};
	wire [15:0] ext12 = {{4{raw[11]}}, raw[11:0]};
	wire [15:0] ext14 = {{2{raw[13]}}, raw[13:0]};
	wire [15:0] ext = res_ff == sas_pkg::RES_8 ? ext8 : res_ff == sas_pkg::RES_10 ? ext10
		: res_ff == sas_pkg::RES_12 ? ext12 : ext14;
	wire cap_ev = cap_done && run_ok;
	wire upd = cap_ev && !hold_ff;

	wire [3:0] tsamp = analog_ff[sas_pkg::AN_TSAMP_LSB +: 4];
	wire [5:0] settle = 6'(tsamp) * 6'(sas_pkg::TSAMP_MULT) + 6'(sas_pkg::TSAMP_MULT);

	always_ff @(posedge clock) begin
		if (reset) begin
			st_ff <= sas_pkg::SAS_IDLE;
			cnt_ff <= '0;
			run_ff <= 1'b0;
			valid_ff <= 1'b0;
			result_ff <= '0;
			data_s1_ff <= '0;
			data_s2_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			run_ff <= enter_cap;
			valid_ff <= cap_ev;
			data_s1_ff <= conv_data;
			data_s2_ff <= data_s1_ff;
			if (upd) begin
				result_ff <= ext;
			end
		end
	end

	// Analog controls are loaded during Set so a mid-capture write cannot disturb a conversion.
	always_ff @(posedge clock) begin
		if (reset) begin
			vref_ff <= sas_pkg::VREF_RST;
			scale_ff <= sas_pkg::SCALE_RST;
			res_ff <= sas_pkg::RES_RST;
			diff_ff <= 1'b0;
			ain_ff <= '0;
			settle_ff <= 6'(sas_pkg::TSAMP_MULT);
		end else if (st_ff == sas_pkg::SAS_SET) begin
			vref_ff <= analog_ff[sas_pkg::AN_VREF_LSB +: 2];
			scale_ff <= analog_ff[sas_pkg::AN_SCALE_LSB +: 2];
			res_ff <= analog_ff[sas_pkg::AN_RES_LSB +: 2];
			diff_ff <= analog_ff[sas_pkg::AN_DIFF_BIT];
			ain_ff <= insel_ff;
			settle_ff <= settle;
		end
	end

	// Registers.
	always_ff @(posedge clock) begin
		if (reset) begin
			pd_ff <= sas_pkg::CTRL_PD_RST;
			hold_ff <= sas_pkg::CTRL_HOLD_RST;
			div_ff <= sas_pkg::CLKDIV_RST;
			en_ff <= 1'b0;
			maxst_ff <= sas_pkg::SEQ_MAX_RST;
			setlen_ff <= '0;
			caphi_ff <= '0;
			caplo_ff <= '0;
			analog_ff <= {sas_pkg::TSAMP_RST, sas_pkg::SCALE_RST, 1'b0, 1'b0,
				sas_pkg::RES_RST, sas_pkg::VREF_RST};
			insel_ff <= '0;
			mask_ff <= '0;
		end else if (wr) begin
			if (hit_ctrl) begin
				pd_ff <= pwdata[sas_pkg::CTRL_PD_BIT];
				hold_ff <= pwdata[sas_pkg::CTRL_HOLD_BIT];
			end
			if (hit_div) div_ff <= pwdata[DIV_W-1:0];
			if (hit_seq) begin
				en_ff <= pwdata[sas_pkg::SEQ_EN_BIT];
				maxst_ff <= pwdata[sas_pkg::SEQ_MAX_LSB +: 2];
			end
			if (hit_setlen) begin
				setlen_ff <= pwdata[SET_W-1:0];
				caphi_ff <= pwdata[sas_pkg::SETLEN_CAPHI_LSB +: 2];
			end
			if (hit_caplo) caplo_ff <= pwdata[7:0];
			if (hit_analog) analog_ff <= pwdata[11:0];
			if (hit_insel) insel_ff <= pwdata[7:0];
			if (hit_mask) mask_ff <= pwdata[1:0];
		end
	end

	// Sticky events: done on each capture, overrun when a done is still pending.
	// Set wins over the read-clear in the same cycle.
	wire [1:0] ev = {cap_ev && stat_ff[sas_pkg::IRQ_DONE_BIT], cap_ev};
	wire irq_rd = rd && hit_irq;
	always_ff @(posedge clock) begin
		if (reset) begin
			stat_ff <= '0;
		end else begin
			stat_ff <= (irq_rd ? 2'h0 : stat_ff) | ev;
		end
	end
	assign irq = |(stat_ff & mask_ff);

	// Read mux.
	wire [31:0] rd_ctrl = {30'h0, hold_ff, pd_ff};
	wire [31:0] rd_seq = {26'h0, maxst_ff, 1'b0, en_ff, 2'h0};
	wire [31:0] rd_setlen = {24'h0, caphi_ff, 2'h0, setlen_ff};
	wire [31:0] rd_status = {29'h0, st_ff, valid_ff};
	always_comb begin
		prdata = 32'h0;
		if (hit_ctrl) prdata = rd_ctrl;
		if (hit_div) prdata = {29'h0, div_ff};
		if (hit_seq) prdata = rd_seq;
		if (hit_setlen) prdata = rd_setlen;
		if (hit_caplo) prdata = {24'h0, caplo_ff};
		if (hit_analog) prdata = {20'h0, analog_ff};
		if (hit_insel) prdata = {24'h0, insel_ff};
		if (hit_result) prdata = {16'h0, result_ff};
		if (hit_status) prdata = rd_status;
		if (hit_irq) prdata = {30'h0, stat_ff};
		if (hit_mask) prdata = {30'h0, mask_ff};
	end

	sas_clkdiv #(
		.DIV_W(DIV_W)
	) u_div (
		.clock(clock),
		.reset(reset),
		.enable(!pd_ff),
		.div(div_ff),
		.conv_clk(conv_clk),
		.tick()
	);

	assign conv_power_down = pd_ff;
	assign conv_run = run_ff;
	assign conv_diff_mode = diff_ff;
	assign conv_ain_pos = ain_ff[7:4];
	assign conv_ain_neg = ain_ff[3:0];
	assign conv_vref_sel = vref_ff;
	assign input_scale_select = scale_ff;
	assign conv_res_sel = res_ff;
	assign conv_settle_cycles = settle_ff;
	assign result_valid_flag = valid_ff;
	assign result = result_ff;
endmodule

/* verif/sas_conv_model.sv */
// Behavioural converter core that returns a sample on each run pulse.
`timescale 1ns/100ps
module sas_conv_model (
	// Core side.
	input wire logic clock,
	input wire logic conv_power_down,
	input wire logic conv_run,
	// Bench side.
	input wire logic [15:0] sample,
	output logic [15:0] conv_data
);
	logic [15:0] held_ff = 16'h0000;
	// A powered-down core inverts its held data every cycle, so stale data can never look valid.
	always @(posedge clock) begin
		if (conv_power_down) begin
			held_ff <= ~held_ff;
		end else if (conv_run) begin
			held_ff <= sample;
		end
	end
	assign conv_data = held_ff;
endmodule

/* verif/sas_props.sv */
// Port assertions for the converter auto sequencer.
`timescale 1ns/100ps
module sas_props (
	// System.
	input wire logic clock,
	input wire logic reset,
	// Bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Converter side.
	input wire logic conv_power_down,
	input wire logic conv_clk,
	input wire logic conv_run,
	input wire logic [1:0] conv_res_sel,
	input wire logic [5:0] conv_settle_cycles,
	input wire logic result_valid_flag,
	input wire logic [15:0] result
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence s_pulse(sig);
		sig ##1 !sig;
	endsequence
	sequence s_down;
		conv_power_down ##1 conv_power_down;
	endsequence
	a_run_pulse: assert property (conv_run |-> s_pulse(conv_run))
		else $error("run pulse too long");
	a_valid_pulse: assert property (result_valid_flag |-> s_pulse(result_valid_flag))
		else $error("valid flag not a pulse");
	a_down_no_run: assert property (s_down |-> !conv_run)
		else $error("run while powered down");
	a_down_clk_low: assert property (s_down |-> !conv_clk)
		else $error("converter clock runs while powered down");
	a_result_update: assert property ($changed(result) |-> result_valid_flag)
		else $error("result changed outside capture end");
	a_sign_14: assert property (result_valid_flag && conv_res_sel == 2'h3 |->
		result[15:14] == {2{result[13]}}) else $error("bad sign extension at 14 bits");
	a_sign_8: assert property (result_valid_flag && conv_res_sel == 2'h0 |->
		result[15:8] == {8{result[7]}}) else $error("bad sign extension at 8 bits");
	a_settle_map: assert property (conv_settle_cycles % 3 == 0 && conv_settle_cycles != 0)
		else $error("settle count off the three-cycle grid");
	a_bus_ready: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
endmodule

bind sas_top sas_props i_sas_props (.clock, .reset, .psel, .penable, .pready, .pslverr,
	.conv_power_down, .conv_clk, .conv_run, .conv_res_sel, .conv_settle_cycles,
	.result_valid_flag, .result);

/* verif/sar_adc_auto_sequencer_tb.sv */
// Self-checking bench for the converter auto sequencer.
`timescale 1ns/100ps
module sar_adc_auto_sequencer_tb;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [15:0] sample = 16'h0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq, pd, cclk, run, diff, valid, err;
	logic [3:0] ain_p, ain_n;
	logic [1:0] vref, scale, res;
	logic [5:0] settle;
	logic [15:0] cdata, result;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	int t0, t1, s, c, sl, cl, ts, sc, vr, inx;
	always #5 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;
	sas_top i_sas_top (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq, .conv_power_down(pd), .conv_clk(cclk), .conv_run(run),
		.conv_diff_mode(diff), .conv_ain_pos(ain_p), .conv_ain_neg(ain_n), .conv_vref_sel(vref),
		.input_scale_select(scale), .conv_res_sel(res), .conv_settle_cycles(settle),
		.conv_data(cdata), .result_valid_flag(valid), .result);
	sas_conv_model i_sas_conv_model (.clock, .conv_power_down(pd), .conv_run(run), .sample,
		.conv_data(cdata));
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			n_mismatch++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_valid(output int t);
		for (int n = 0; n < 3000 && valid !== 1'b1; n++) @(posedge clock);
		if (valid !== 1'b1) begin
			n_mismatch++;
			complete_run();
		end
		t = cyc;
		@(posedge clock);
	endtask
	task automatic rise(output int t);
		logic p;
		p = cclk;
		for (int n = 0; n < 100 && !(cclk === 1'b1 && p === 1'b0); n++) begin
			p = cclk;
			@(posedge clock);
		end
		if (!(cclk === 1'b1 && p === 1'b0)) begin
			n_mismatch++;
			complete_run();
		end
		t = cyc;
	endtask
	// The valid width grows two bits per resolution step; the rest copies its top bit.
	function automatic logic [15:0] sext(input logic [15:0] v, input int r);
		logic [15:0] m;
		m = 16'hffff << (8 + 2 * r);
		return v[7 + 2 * r] ? (v | m) : (v & ~m);
	endfunction
	initial begin
		s = $urandom(16);
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		apb(1'b0, sas_pkg::OFF_CTRL, 32'h0);
		chk("ctrl reset", 32'h1, rd);
		chk("power down pin", 32'h1, pd);
		apb(1'b0, sas_pkg::OFF_CLKDIV, 32'h0);
		chk("divider reset", 32'h3, rd);
		apb(1'b1, sas_pkg::OFF_CTRL, 32'h0);
		for (c = 0; c < 3; c++) begin
			s = c == 0 ? 7 : $urandom_range(1, 6);
			apb(1'b1, sas_pkg::OFF_CLKDIV, 32'(s));
			rise(t0);
			rise(t0);
			rise(t1);
			chk("converter clock period", 32'(s + 1), 32'(t1 - t0));
		end
		$display("test clock done");
		for (c = 0; c < 4; c++) begin
			sl = c == 0 ? 1 : $urandom_range(1, 15);
			cl = c == 3 ? 1023 : (c == 0 ? 4 : $urandom_range(4, 300));
			ts = $urandom_range(0, 15);
			sc = $urandom_range(0, 3);
			vr = c == 0 ? 2 : $urandom_range(0, 3);
			inx = $urandom_range(0, 255);
			sample <= 16'($urandom);
			apb(1'b1, sas_pkg::OFF_SEQ, 32'h0);
			apb(1'b1, sas_pkg::OFF_SETLEN, 32'((cl / 256) * 64 + sl));
			apb(1'b1, sas_pkg::OFF_CAPLO, 32'(cl % 256));
			apb(1'b1, sas_pkg::OFF_ANALOG, 32'(ts * 256 + sc * 64 + 16 + c * 4 + vr));
			apb(1'b1, sas_pkg::OFF_INSEL, 32'(inx));
			apb(1'b1, sas_pkg::OFF_SEQ, 32'h24);
			wait_valid(t0);
			wait_valid(t1);
			chk("sample period", 32'(sl + cl), 32'(t1 - t0));
			chk("result", 32'(sext(sample, c)), 32'(result));
			chk("controls",
				{11'(1024 + inx * 4 + vr), 2'(sc), 2'(c), 6'(3 * (ts + 1))},
				{diff, ain_p, ain_n, vref, scale, res, settle});
			apb(1'b0, sas_pkg::OFF_RESULT, 32'h0);
			chk("result register", 32'(sext(sample, c)), rd);
		end
		$display("test sequencer done");
		apb(1'b1, sas_pkg::OFF_CTRL, 32'h2);
		sample <= ~sample;
		wait_valid(t0);
		wait_valid(t0);
		chk("held result", 32'(sext(~sample, 3)), 32'(result));
		apb(1'b1, sas_pkg::OFF_CTRL, 32'h0);
		wait_valid(t0);
		wait_valid(t0);
		chk("released result", 32'(sext(sample, 3)), 32'(result));
		$display("test hold done");
		apb(1'b1, sas_pkg::OFF_MASK, 32'h0);
		@(posedge clock);
		chk("masked irq", 32'h0, irq);
		for (c = 0; c < 2; c++) begin
			apb(1'b1, sas_pkg::OFF_SEQ, c ? 32'h14 : 32'h20);
			// A capture launched in the last enabled cycle may still pulse run once.
			@(posedge clock);
			s = 0;
			repeat (1500) begin
				@(posedge clock);
				s += run;
			end
			chk("runs while stopped", 32'h0, 32'(s));
		end
		apb(1'b0, sas_pkg::OFF_STATUS, 32'h0);
		chk("status idle", 32'h0, rd);
		apb(1'b1, sas_pkg::OFF_MASK, 32'h1);
		@(posedge clock);
		chk("irq raised", 32'h1, irq);
		apb(1'b0, sas_pkg::OFF_IRQ, 32'h0);
		chk("done status", 32'h1, rd[0]);
		chk("overrun status", 32'h1, rd[1]);
		@(posedge clock);
		chk("irq cleared", 32'h0, irq);
		apb(1'b0, 12'h0fc, 32'h0);
		chk("unmapped error", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		$display("test irq and bus done");
		complete_run();
	end
endmodule
